// ---- rtl/iop_cfg.svh ----
// Register offsets, field positions, reset values and fixed codes of the port permission checker.
// Included by the checker's top-level design file only; holds definitions only.
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

`define IOP_OFF_CTRL 12'h000
`define IOP_OFF_MAPBASE 12'h004
`define IOP_OFF_LIMIT 12'h008
`define IOP_OFF_MADDR 12'h00C
`define IOP_OFF_MDATA 12'h010
`define IOP_OFF_STATUS 12'h014

`define IOP_CTRL_PE 0
`define IOP_CTRL_V86 1
`define IOP_CTRL_IOPRIV_LO 2
`define IOP_CTRL_IOPRIV_HI 3
`define IOP_CTRL_CURPRIV_LO 4
`define IOP_CTRL_CURPRIV_HI 5

`define IOP_ST_BUSY 0
`define IOP_ST_FAULT 1

`define IOP_RST_CTRL 6'h00
`define IOP_RST_MAPBASE 16'hFFFF
`define IOP_RST_LIMIT 16'h0000

`define IOP_BIT_SHIFT 3
`define IOP_MASK_BYTE 4'h1
`define IOP_MASK_WORD 4'h3
`define IOP_MASK_DWORD 4'hF

`endif

// ---- rtl/iop_pkg.sv ----
// Types shared by the port permission checker and its bench.
// Assumes a single core clock domain.
`default_nettype none

package iop_pkg;

   typedef enum logic [2:0]
   {
      IOP_K_IN = 3'h0,
      IOP_K_OUT = 3'h1,
      IOP_K_MEM_RD_WB = 3'h2,
      IOP_K_MEM_RD_UC = 3'h3,
      IOP_K_MEM_WR_UC = 3'h4,
      IOP_K_SERIAL = 3'h5
   } iop_kind_t;

   typedef enum logic [1:0]
   {
      IOP_SZ_BYTE = 2'h0,
      IOP_SZ_WORD = 2'h1,
      IOP_SZ_DWORD = 2'h2
   } iop_size_t;

   typedef struct packed
   {
      iop_kind_t kind;
      iop_size_t size;
      logic str;
      logic repeat_prefix;
      logic [31:0] addr;
      logic [31:0] wdata;
   } iop_op_t;

   typedef struct packed
   {
      logic io_space;
      logic write;
      iop_size_t size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } iop_bus_t;

   typedef enum logic [7:0]
   {
      IOP_S_IDLE = 8'h01,
      IOP_S_WAIT_ST = 8'h02,
      IOP_S_FETCH0 = 8'h04,
      IOP_S_FETCH1 = 8'h08,
      IOP_S_CHECK = 8'h10,
      IOP_S_BUS = 8'h20,
      IOP_S_DRAIN = 8'h40,
      IOP_S_DONE = 8'h80
   } iop_state_t;

endpackage

`default_nettype wire

// ---- rtl/iop_map_mem.sv ----
// Byte memory holding the task state segment image that the permission map is read from.
// Assumes one clock; read data comes out of a register one cycle after the address.
`default_nettype none

module iop_map_mem #(
   parameter int AW = 10,
   parameter int DW = 8
)(
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk)
   begin
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// ---- rtl/iop_top.sv ----
// Port permission checker and I/O ordering sequencer, with APB registers and a map memory.
// Assumes synchronous inputs on CORE_CLK, an APB master, and an external write buffer
// reporting STORES_PENDING.
//
// Summary of operation
// (RULE1) Protected mode with privilege level not above I/O field: no map check.
// (RULE2) Privilege above I/O field or virtual-8086 mode: map is consulted first.
// (RULE3) One map bit per byte port, ascending port order.
// (RULE4) Multi-byte access tests the bit of every byte port covered.
// (RULE5) Any tested bit set: fault, no bus cycle.
// (RULE6) All tested bits clear: access goes out on the bus.
// (RULE7) Map located from the task segment's map-base offset.
// (RULE8) Two consecutive map bytes fetched for every checked access.
// (RULE9) Software places an all-ones byte after the map, inside the limit.
// (RULE10) Map bytes beyond the segment limit read as all ones.
// (RULE11) Map base at or above limit: map absent, checked accesses fault.
// (RULE12) Cacheable reads may pass pending buffered writes.
// (RULE13) Uncacheable reads and writes reach the pins in program order.
// (RULE14) Software marks ordered memory-mapped ranges uncacheable.
// (RULE15) Serializing operation completes all earlier work before later ones.
// (RULE16) Port writes are never buffered; port operations stay in order.
// (RULE17) Port input waits for all pending stores before starting.
// (RULE18) Port output holds off the next operation until all stores complete.
// (RULE19) Port transfers of 8, 16 or 32 bits over consecutive byte ports.
// (RULE20) Byte index is port shifted right three; bit index is low three bits.
// (RULE21) Check applies only to port input and output, string forms included.
`include "iop_cfg.svh"
`default_nettype none

module iop_top #(
   parameter int MAP_AW = 10
)(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OP_VALID,
   input wire iop_pkg::iop_op_t OP,
   output logic OP_READY,
   output logic RESP_VALID,
   output logic RESP_FAULT,
   output logic [31:0] RESP_DATA,
   output logic BUS_REQ,
   output iop_pkg::iop_bus_t BUS,
   input wire logic BUS_DONE,
   input wire logic [31:0] BUS_RDATA,
   input wire logic STORES_PENDING
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic [3:0] size_mask(input iop_pkg::iop_size_t sz);
      case (sz)
         iop_pkg::IOP_SZ_BYTE: size_mask = `IOP_MASK_BYTE;
         iop_pkg::IOP_SZ_WORD: size_mask = `IOP_MASK_WORD;
         default: size_mask = `IOP_MASK_DWORD;
      endcase
   endfunction

   function automatic logic is_io(input iop_pkg::iop_kind_t k);
      is_io = (k == iop_pkg::IOP_K_IN) || (k == iop_pkg::IOP_K_OUT);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // APB registers

   logic [5:0] ctrl;
   logic [15:0] map_base;
   logic [15:0] seg_limit;
   logic [MAP_AW-1:0] mem_addr;
   logic last_fault;
   logic apb_access;
   logic apb_wr;
   logic addr_ok;
   logic [31:0] rd_mux;
   iop_pkg::iop_state_t state;
   iop_pkg::iop_state_t next_state;

   assign apb_access = PSEL && PENABLE && PREADY;
   assign apb_wr = apb_access && PWRITE;

   // One wait state keeps PREADY a plain flop
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         PREADY <= 1'h0;
      end
      else
      begin
         PREADY <= PSEL && PENABLE && !PREADY;
      end
   end

   always_comb
   begin
      addr_ok = 1'h1;
      rd_mux = 32'h0000_0000;
      case (PADDR)
         `IOP_OFF_CTRL: rd_mux = 32'(ctrl);
         `IOP_OFF_MAPBASE: rd_mux = 32'(map_base);
         `IOP_OFF_LIMIT: rd_mux = 32'(seg_limit);
         `IOP_OFF_MADDR: rd_mux = 32'(mem_addr);
         `IOP_OFF_MDATA: rd_mux = 32'h0000_0000;
         `IOP_OFF_STATUS:
         begin
            rd_mux[`IOP_ST_BUSY] = (state != iop_pkg::IOP_S_IDLE);
            rd_mux[`IOP_ST_FAULT] = last_fault;
         end
         default: addr_ok = 1'h0;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'h0;
      end
      else
      begin
         PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rd_mux : 32'h0000_0000;
         PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
      end
   end

   // Changing mode fields mid-operation is harmless: the need for a check is latched at take
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         ctrl <= `IOP_RST_CTRL;
         map_base <= `IOP_RST_MAPBASE;
         seg_limit <= `IOP_RST_LIMIT;
      end
      else if (apb_wr)
      begin
         case (PADDR)
            `IOP_OFF_CTRL: ctrl <= PWDATA[5:0];
            `IOP_OFF_MAPBASE: map_base <= PWDATA[15:0];
            `IOP_OFF_LIMIT: seg_limit <= PWDATA[15:0];
            default: ;
         endcase
      end
   end

   // Data writes step the address so a segment image loads as a stream
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         mem_addr <= '0;
      end
      else if (apb_wr && PADDR == `IOP_OFF_MADDR)
      begin
         mem_addr <= PWDATA[MAP_AW-1:0];
      end
      else if (apb_wr && PADDR == `IOP_OFF_MDATA)
      begin
         mem_addr <= mem_addr + 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Map memory and map addressing

   iop_pkg::iop_op_t cur;
   logic chk_need;
   logic next_need;
   logic op_take;
   logic [16:0] off0;
   logic [16:0] off1;
   logic [MAP_AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] byte0;
   logic [7:0] byte1;
   logic out0;
   logic out1;
   logic map_absent;
   logic [15:0] window;
   logic fault_now;

   iop_map_mem #(
      .AW(MAP_AW),
      .DW(8)
   ) u_mem (
      .clk(CORE_CLK),
      .wr_en(apb_wr && PADDR == `IOP_OFF_MDATA),
      .wr_addr(mem_addr),
      .wr_data(PWDATA[7:0]),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   assign off0 = {1'h0, map_base} + 17'(cur.addr[15:`IOP_BIT_SHIFT]); // [RULE7] [RULE20]
   assign off1 = off0 + 17'h0_0001; // [RULE8]
   assign rd_addr = (state == iop_pkg::IOP_S_FETCH0) ? off0[MAP_AW-1:0] : off1[MAP_AW-1:0];
   assign out0 = (off0 > {1'h0, seg_limit}) || (off0 >= 17'(1 << MAP_AW)); // [RULE10]
   assign out1 = (off1 > {1'h0, seg_limit}) || (off1 >= 17'(1 << MAP_AW)); // [RULE10]
   assign map_absent = (map_base >= seg_limit); // [RULE11]
   assign byte1 = out1 ? 8'hFF : rd_data;
   assign window = {byte1, byte0} >> cur.addr[2:0]; // [RULE3] [RULE20]
   assign fault_now = map_absent || (|(window[3:0] & size_mask(cur.size))); // [RULE4] [RULE5] [RULE19]

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         byte0 <= 8'h00;
      end
      else if (state == iop_pkg::IOP_S_FETCH1)
      begin
         byte0 <= out0 ? 8'hFF : rd_data; // [RULE10]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Real mode checks nothing; protected mode checks above the field; v86 always checks
   assign next_need = is_io(OP.kind) && (ctrl[`IOP_CTRL_V86] ||
      (ctrl[`IOP_CTRL_PE] && (ctrl[`IOP_CTRL_CURPRIV_HI:`IOP_CTRL_CURPRIV_LO] >
      ctrl[`IOP_CTRL_IOPRIV_HI:`IOP_CTRL_IOPRIV_LO]))); // [RULE1] [RULE2] [RULE21]
   assign op_take = OP_VALID && OP_READY && (state == iop_pkg::IOP_S_IDLE);

   always_comb
   begin
      next_state = state;
      case (state)
         iop_pkg::IOP_S_IDLE:
         begin
            if (op_take)
            begin
               case (OP.kind)
                  iop_pkg::IOP_K_SERIAL: next_state = iop_pkg::IOP_S_DRAIN; // [RULE15]
                  iop_pkg::IOP_K_OUT: next_state = next_need ? iop_pkg::IOP_S_FETCH0 : iop_pkg::IOP_S_BUS;
                  iop_pkg::IOP_K_MEM_RD_WB: next_state = iop_pkg::IOP_S_BUS; // [RULE12]
                  default: next_state = iop_pkg::IOP_S_WAIT_ST; // [RULE13] [RULE17]
               endcase
            end
         end
         iop_pkg::IOP_S_WAIT_ST:
         begin
            if (!STORES_PENDING)
            begin
               next_state = chk_need ? iop_pkg::IOP_S_FETCH0 : iop_pkg::IOP_S_BUS; // [RULE17]
            end
         end
         iop_pkg::IOP_S_FETCH0: next_state = iop_pkg::IOP_S_FETCH1; // [RULE8]
         iop_pkg::IOP_S_FETCH1: next_state = iop_pkg::IOP_S_CHECK;
         iop_pkg::IOP_S_CHECK: next_state = fault_now ? iop_pkg::IOP_S_DONE : iop_pkg::IOP_S_BUS; // [RULE5] [RULE6]
         iop_pkg::IOP_S_BUS:
         begin
            if (BUS_DONE)
            begin
               // The output's own store completes before anything follows
               next_state = (cur.kind == iop_pkg::IOP_K_OUT) ? iop_pkg::IOP_S_DRAIN : iop_pkg::IOP_S_DONE; // [RULE16]
            end
         end
         iop_pkg::IOP_S_DRAIN:
         begin
            if (!STORES_PENDING)
            begin
               next_state = iop_pkg::IOP_S_DONE; // [RULE15] [RULE18]
            end
         end
         iop_pkg::IOP_S_DONE: next_state = iop_pkg::IOP_S_IDLE;
         default: next_state = iop_pkg::IOP_S_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         state <= iop_pkg::IOP_S_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // One operation at a time: nothing is accepted until the previous one answered
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         OP_READY <= 1'h0;
         RESP_VALID <= 1'h0;
      end
      else
      begin
         OP_READY <= (next_state == iop_pkg::IOP_S_IDLE) && !op_take; // [RULE15] [RULE16]
         RESP_VALID <= (next_state == iop_pkg::IOP_S_DONE);
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         cur <= '0;
         chk_need <= 1'h0;
      end
      else if (op_take)
      begin
         cur <= OP;
         chk_need <= next_need;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         RESP_FAULT <= 1'h0;
         last_fault <= 1'h0;
      end
      else if (op_take)
      begin
         RESP_FAULT <= 1'h0;
      end
      else if (state == iop_pkg::IOP_S_CHECK)
      begin
         RESP_FAULT <= fault_now; // [RULE5]
         last_fault <= fault_now;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         RESP_DATA <= 32'h0000_0000;
      end
      else if (op_take)
      begin
         RESP_DATA <= 32'h0000_0000;
      end
      else if (state == iop_pkg::IOP_S_BUS && BUS_DONE && !BUS.write)
      begin
         RESP_DATA <= BUS_RDATA;
      end
   end

   // Port writes go straight to the bus request, never into a buffer
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         BUS_REQ <= 1'h0;
         BUS <= '0;
      end
      else
      begin
         BUS_REQ <= (next_state == iop_pkg::IOP_S_BUS); // [RULE6] [RULE16]
         if (op_take)
         begin
            BUS.io_space <= is_io(OP.kind);
            BUS.write <= (OP.kind == iop_pkg::IOP_K_OUT) || (OP.kind == iop_pkg::IOP_K_MEM_WR_UC);
            BUS.size <= OP.size; // [RULE19]
            BUS.addr <= OP.addr;
            BUS.wdata <= OP.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_fetch_pair;
      state == iop_pkg::IOP_S_FETCH0 ##1 state == iop_pkg::IOP_S_FETCH1 ##1 state == iop_pkg::IOP_S_CHECK;
   endsequence

   sequence s_fault_answer;
      (state == iop_pkg::IOP_S_DONE && RESP_VALID && RESP_FAULT && !BUS_REQ) ##1 state == iop_pkg::IOP_S_IDLE;
   endsequence

   a_priv_bypass: assert property (op_take && is_io(OP.kind) && ctrl[`IOP_CTRL_PE] && // [RULE1]
      !ctrl[`IOP_CTRL_V86] && ctrl[`IOP_CTRL_CURPRIV_HI:`IOP_CTRL_CURPRIV_LO] <=
      ctrl[`IOP_CTRL_IOPRIV_HI:`IOP_CTRL_IOPRIV_LO] |=> !chk_need)
      else $error("privileged port access was sent to the map check");

   a_need_check: assert property (op_take && is_io(OP.kind) && ctrl[`IOP_CTRL_V86] |=> chk_need) // [RULE2]
      else $error("virtual-8086 port access skipped the map check");

   a_fetch_pair: assert property (state == iop_pkg::IOP_S_FETCH0 |-> s_fetch_pair) // [RULE8]
      else $error("map byte pair fetch sequence broken");

   a_fault_no_bus: assert property (state == iop_pkg::IOP_S_CHECK && fault_now |=> s_fault_answer) // [RULE5]
      else $error("faulting access did not answer with a fault");

   a_pass_to_bus: assert property (state == iop_pkg::IOP_S_CHECK && !fault_now |=> BUS_REQ && !RESP_FAULT) // [RULE6]
      else $error("permitted access did not reach the bus");

   a_absent_map: assert property (state == iop_pkg::IOP_S_CHECK && map_absent |-> fault_now) // [RULE11]
      else $error("absent map did not fault");

   a_beyond_limit: assert property (state == iop_pkg::IOP_S_CHECK && out1 && cur.addr[2:0] == 3'h7 && // [RULE10]
      cur.size != iop_pkg::IOP_SZ_BYTE |-> fault_now)
      else $error("map bit beyond limit read as clear");

   a_in_waits: assert property ($rose(BUS_REQ) && cur.kind == iop_pkg::IOP_K_IN |-> // [RULE17]
      !$past(STORES_PENDING) || chk_need)
      else $error("port input started with stores pending");

   a_out_drains: assert property (RESP_VALID && cur.kind == iop_pkg::IOP_K_OUT && !RESP_FAULT // [RULE18]
      |-> !$past(STORES_PENDING) && $past(state, 2) != iop_pkg::IOP_S_IDLE)
      else $error("port output answered before stores drained");

   a_serial_hold: assert property (state == iop_pkg::IOP_S_DRAIN && STORES_PENDING |=> // [RULE15]
      !RESP_VALID && !OP_READY)
      else $error("serialization released with stores pending");

   a_bus_order: assert property (BUS_REQ && BUS_DONE && cur.kind != iop_pkg::IOP_K_OUT |=> // [RULE13]
      RESP_VALID ##1 OP_READY)
      else $error("bus completion did not answer in order");

endmodule

`default_nettype wire

// ---- bench/iop_bus_model.sv ----
// Behavioural model of the external bus that answers the checker's bus cycles.
// Assumes the design's clock; each answer comes after 0 to 3 idle cycles.
`default_nettype none

module iop_bus_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_req,
   input wire iop_pkg::iop_bus_t bus,
   output logic bus_done,
   output logic [31:0] bus_rdata,
   output var int n_cycles,
   output iop_pkg::iop_bus_t last_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bus_done <= 1'b0;
         bus_rdata <= 32'h0000_0000;
         n_cycles <= 0;
         wait_cnt <= 0;
         last_bus <= '0;
      end
      else if (bus_done)
      begin
         // Released data is inverted so a stale value never passes for an answer
         bus_done <= 1'b0;
         bus_rdata <= ~bus_rdata;
      end
      else if (bus_req && wait_cnt != 0)
         wait_cnt <= wait_cnt - 1;
      else if (bus_req)
      begin
         // Every cycle that reaches the bus is counted, and the latest one is kept in last_bus
         bus_done <= 1'b1;
         bus_rdata <= bus.addr ^ 32'h5a5a_c3c3;
         n_cycles <= n_cycles + 1;
         last_bus <= bus;
         wait_cnt <= $urandom_range(3);
      end
   end
endmodule

`default_nettype wire

// ---- bench/iop_top_tb_top.sv ----
// Self-checking bench for the port permission checker, with a reference model of the map.
// Assumes the bus model answers every bus cycle and the bench plays the store buffer.
`default_nettype none

module iop_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA, RESP_DATA, BUS_RDATA;
   logic PREADY, PSLVERR, OP_READY, RESP_VALID, RESP_FAULT, BUS_REQ, BUS_DONE;
   logic OP_VALID = 1'b0;
   logic STORES_PENDING = 1'b0;
   iop_pkg::iop_op_t OP = '0;
   iop_pkg::iop_bus_t BUS, last_bus;
   int n_errors = 0;
   int comparisons = 0;
   int n_bus, pe, v86, io_priv, cur_priv, mapbase, limit, i;
   int mem [1024];

   ////////////////////////////////////////////////////////////////////////////////
   iop_top #(.MAP_AW(10)) u_iop_top (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .OP_VALID(OP_VALID), .OP(OP), .OP_READY(OP_READY), .RESP_VALID(RESP_VALID), .RESP_FAULT(RESP_FAULT),
      .RESP_DATA(RESP_DATA), .BUS_REQ(BUS_REQ), .BUS(BUS), .BUS_DONE(BUS_DONE), .BUS_RDATA(BUS_RDATA),
      .STORES_PENDING(STORES_PENDING));
   iop_bus_model u_iop_bus_model (.clk(CORE_CLK), .rst(RST), .bus_req(BUS_REQ), .bus(BUS),
      .bus_done(BUS_DONE), .bus_rdata(BUS_RDATA), .n_cycles(n_bus), .last_bus(last_bus));

   always #2 CORE_CLK = ~CORE_CLK;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Request held until the edge that samples PREADY high; one idle edge after it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do
      begin
         @(posedge CORE_CLK);
      end
      while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CORE_CLK);
   endtask

   task automatic wr(input logic [11:0] a, input int d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, 32'(d), r, e);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
      chk({31'h0000_0000, e}, {31'h0000_0000, xe});
   endtask

   task automatic set_ctrl(input int p, input int v, input int io, input int c);
      pe = p;
      v86 = v;
      io_priv = io;
      cur_priv = c;
      wr(12'h000, (c << 4) | (io << 2) | (v << 1) | p);
   endtask

   task automatic set_map(input int b, input int l);
      mapbase = b;
      limit = l;
      wr(12'h004, b);
      wr(12'h008, l);
   endtask

   task automatic poke(input int o, input int v);
      mem[o] = v;
      wr(12'h00C, o);
      wr(12'h010, v);
   endtask

   function automatic int mbyte(input int o);
      return (o > limit || o > 1023) ? 255 : mem[o];
   endfunction

   function automatic logic exp_fault(input int k, input int sz, input int port);
      int w;
      if (k > 1 || !(v86 == 1 || (pe == 1 && cur_priv > io_priv)))
         return 1'b0;
      if (mapbase >= limit)
         return 1'b1;
      w = mbyte(mapbase + (port >> 3)) | (mbyte(mapbase + (port >> 3) + 1) << 8);
      return ((w >> (port & 7)) & ((1 << (1 << sz)) - 1)) != 0;
   endfunction

   // Stall holds the store buffer busy for that many cycles after the take
   task automatic run_op(input int k, input int sz, input int port, input int stall);
      logic f;
      int n, nb;
      logic blk_bus, blk_resp;
      logic [31:0] wd;
      f = exp_fault(k, sz, port);
      nb = n_bus;
      wd = $urandom;
      blk_bus = (k == 0 || k == 3 || k == 4);
      blk_resp = (k != 2) && !(f && k == 1);
      // One edge apart from the previous op's store clear, so the pin is never driven twice in a step
      if (stall > 0)
      begin
         @(posedge CORE_CLK);
         STORES_PENDING <= 1'b1;
      end
      OP_VALID <= 1'b1;
      OP <= '{kind: iop_pkg::iop_kind_t'(k), size: iop_pkg::iop_size_t'(sz), str: 1'($urandom_range(1)),
         repeat_prefix: 1'($urandom_range(1)), addr: 32'(port), wdata: wd};
      n = 0;
      do
      begin
         @(posedge CORE_CLK);
         n++;
      end
      while (OP_READY !== 1'b1 && n < 200);
      OP_VALID <= 1'b0;
      for (n = 0; n < 200; n++)
      begin
         @(posedge CORE_CLK);
         if (n == stall - 1)
            STORES_PENDING <= 1'b0;
         if (n <= stall && stall > 0 && blk_bus)
            chk({31'h0000_0000, BUS_REQ}, 32'h0000_0000);
         if (n <= stall && stall > 0 && blk_resp)
            chk({31'h0000_0000, RESP_VALID}, 32'h0000_0000);
         if (RESP_VALID === 1'b1)
            break;
      end
      if (n < stall - 1)
         STORES_PENDING <= 1'b0;
      chk({31'h0000_0000, RESP_VALID}, 32'h0000_0001);
      chk({31'h0000_0000, RESP_FAULT}, {31'h0000_0000, f});
      chk(RESP_DATA, (!f && (k == 0 || k == 2 || k == 3)) ? 32'(port) ^ 32'h5a5a_c3c3 : 32'h0000_0000);
      chk(32'(n_bus - nb), (f || k == 5) ? 32'h0000_0000 : 32'h0000_0001);
      if (!f && k != 5)
      begin
         chk(last_bus.addr, 32'(port));
         chk(32'(last_bus.io_space), 32'(k < 2));
         chk(32'(last_bus.write), 32'(k == 1 || k == 4));
         chk(32'(last_bus.size), 32'(sz));
         chk(last_bus.wdata, wd);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (40000) @(posedge CORE_CLK);
      n_errors++;
      results();
   end

   initial
   begin
      void'($urandom(32'hedc0_19f2));
      mapbase = 16'hffff;
      limit = 0;
      repeat (8) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(posedge CORE_CLK);
      rdc(12'h000, 32'h0000_0000, 1'b0);
      rdc(12'h004, 32'h0000_ffff, 1'b0);
      rdc(12'h008, 32'h0000_0000, 1'b0);
      rdc(12'h014, 32'h0000_0000, 1'b0);
      rdc(12'h010, 32'h0000_0000, 1'b0);
      rdc(12'h018, 32'h0000_0000, 1'b1);
      run_op(0, 0, 16'h0029, 0);
      set_ctrl(1, 0, 2, 3);
      run_op(0, 2, 16'h0010, 2);
      rdc(12'h014, 32'h0000_0002, 1'b0);
      set_ctrl(1, 0, 3, 3);
      run_op(1, 0, 16'h0010, 2);
      set_ctrl(0, 1, 3, 0);
      run_op(0, 0, 16'h0010, 0);
      for (i = 0; i < 128; i++)
         poke(i, $urandom_range(255));
      poke(16'h0024, 0);
      poke(16'h0025, 2);
      poke(16'h002a, 255);
      set_map(16'h0020, 16'h002a);
      set_ctrl(1, 0, 0, 3);
      run_op(1, 0, 16'h0029, 0);
      run_op(0, 0, 16'h0028, 0);
      run_op(0, 1, 16'h002a, 1);
      run_op(0, 2, 16'h0026, 0);
      run_op(0, 2, 16'h003e, 0);
      run_op(0, 0, 16'h0050, 0);
      run_op(1, 0, 16'h0058, 0);
      for (i = 0; i < 6; i++)
         run_op(i, 1, 16'h0040, 3);
      for (i = 0; i < 240; i++)
      begin
         if (i % 16 == 0)
         begin
            set_ctrl($urandom_range(1), $urandom_range(1), $urandom_range(3), $urandom_range(3));
            set_map(8 + $urandom_range(56), 0);
            set_map(mapbase, mapbase - 2 + $urandom_range(14));
         end
         run_op($urandom_range(5), $urandom_range(2), $urandom_range(111), $urandom_range(3));
      end
      results();
   end
endmodule

`default_nettype wire
